// ===== common/ais_pkg.sv
// Purpose : shared constants and types for the analog input scaling block
// Assumes : object dictionary indices are 16 bits, subindices 8 bits
// Notes   : widths of the scaling arithmetic are fixed here for all files
package ais_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // object dictionary map
  localparam logic [15:0] IDX_SCALED     = 16'h3320;
  localparam logic [15:0] IDX_OFFSET     = 16'h3321;
  localparam logic [15:0] IDX_NUMERATOR  = 16'h3322;
  localparam logic [15:0] IDX_DENOMIN    = 16'h3323;
  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_FIRST      = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] OFFSET_RST     = 16'h0000;
  localparam logic [15:0] NUMERATOR_RST  = 16'h0001;
  localparam logic [15:0] DENOMIN_RST    = 16'h0001;
  localparam logic [31:0] SCALED_RST     = 32'h0000_0000;
  localparam int          NUM_INPUTS_DEF = 1;
  localparam int          MAX_INPUTS     = 2;

  ////////////////////////////////////////////////////////////////////////////
  // converter and arithmetic widths
  localparam int          ADC_W          = 10;
  localparam int          COEF_W         = 16;
  localparam int          SUM_W          = 17;
  localparam int          PROD_W         = 33;
  localparam int          RESULT_W       = 32;
  localparam logic [9:0]  ADC_FULL_SCALE = 10'h3FF;
  localparam int          VOLT_FS_MV     = 10000;
  localparam int          CURR_FS_UA     = 20000;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [0:0] {
    AIS_ST_LOAD,
    AIS_ST_WAIT
  } ais_state_e;

endpackage : ais_pkg

// ===== common/ais_div_if.sv
// Purpose : request and answer of one signed division
// Assumes : start is a one-cycle pulse, done answers it once
// Notes   : operands are sampled on the start cycle only
interface ais_div_if #(
  parameter int DW = 33,
  parameter int VW = 16
);
  logic                 start;
  logic signed [DW-1:0] dividend;
  logic signed [VW-1:0] divisor;
  logic                 done;
  logic signed [DW-1:0] quotient;

  modport req (output start, dividend, divisor, input done, quotient);
  modport rsp (input start, dividend, divisor, output done, quotient);
endinterface : ais_div_if

// ===== logic/ais_divider.sv
// Purpose : iterative signed divider, truncating toward zero
// Assumes : divisor is never zero when start is raised
// Notes   : one quotient bit per clock, done DW+1 edges after start
module ais_divider #(
  parameter int DW = 33,
  parameter int VW = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  ais_div_if.rsp    div
);

  logic [DW-1:0] dvd_r;
  logic [VW-1:0] dvs_r;
  logic [VW:0]   rem_r;
  logic          neg_r;
  logic          busy_r;
  logic [5:0]    cnt_r;
  logic [VW:0]   rem_sh;
  logic          fits;

  ////////////////////////////////////////////////////////////////////////////
  // one restoring step on magnitudes
  always_comb begin
    rem_sh = {rem_r[VW-1:0], dvd_r[DW-1]};
    fits   = (rem_sh >= {1'b0, dvs_r});
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      dvd_r        <= '0;
      dvs_r        <= '0;
      rem_r        <= '0;
      neg_r        <= 1'b0;
      busy_r       <= 1'b0;
      cnt_r        <= '0;
      div.done     <= 1'b0;
      div.quotient <= '0;
    end else begin
      div.done <= 1'b0;
      if (div.start && !busy_r) begin
        dvd_r  <= div.dividend[DW-1] ? DW'(-div.dividend) : DW'(div.dividend);
        dvs_r  <= div.divisor[VW-1] ? VW'(-div.divisor) : VW'(div.divisor);
        neg_r  <= div.dividend[DW-1] ^ div.divisor[VW-1];
        rem_r  <= '0;
        cnt_r  <= 6'(DW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == 6'h00) begin
          busy_r       <= 1'b0;
          div.done     <= 1'b1;
          // truncation toward zero: sign applied to the magnitude quotient
          div.quotient <= neg_r ? DW'(-$signed(dvd_r)) : $signed(dvd_r);
        end else begin
          rem_r <= fits ? (rem_sh - {1'b0, dvs_r}) : rem_sh;
          dvd_r <= {dvd_r[DW-2:0], fits};
          cnt_r <= cnt_r - 6'h01;
        end
      end
    end
  end

endmodule // ais_divider

// ===== logic/ais_scaler.sv
// Purpose : offset, multiply and divide raw converter counts into user units
// Assumes : object dictionary access strobes are single-cycle and synchronous
// Notes   : inputs are processed round robin, one division at a time
//           coefficient writes take effect at the next load of that input
//
// Functional notes
// - scaled value per input, signed 32-bit, read-only, refreshed
// - offset added to raw reading first
// - offset-corrected reading multiplied by numerator
// - product divided by denominator
// - default coefficients report raw counts unchanged
// - current: x counts equals x*20mA/1023
// - subindex zero reads input count, read-only
// - signed 16-bit offset per input, reset zero
// - signed 16-bit numerator per input, writable
// - signed 16-bit divisor per input, reset one
module ais_scaler #(
  parameter int NUM_INPUTS = ais_pkg::NUM_INPUTS_DEF
) (
  input  wire logic                                  clk_sys_i,
  input  wire logic                                  srst_i,
  input  wire logic [NUM_INPUTS*ais_pkg::ADC_W-1:0]  adc_raw_i,
  input  wire logic                                  od_rd_i,
  input  wire logic                                  od_wr_i,
  input  wire logic [15:0]                           od_index_i,
  input  wire logic [7:0]                            od_subidx_i,
  input  wire logic [31:0]                           od_wdata_i,
  output logic      [31:0]                           od_rdata_o,
  output logic                                       od_ack_o,
  output logic                                       od_abort_o,
  output logic                                       refresh_o
);

  localparam int IW = 1;

  logic signed [ais_pkg::COEF_W-1:0]   offset_r   [NUM_INPUTS];
  logic signed [ais_pkg::COEF_W-1:0]   numer_r    [NUM_INPUTS];
  logic signed [ais_pkg::COEF_W-1:0]   denom_r    [NUM_INPUTS];
  logic signed [ais_pkg::RESULT_W-1:0] scaled_r   [NUM_INPUTS];
  logic [IW-1:0]                       idx_r;
  ais_pkg::ais_state_e                 state_r;
  logic [ais_pkg::ADC_W-1:0]           raw_sel;
  logic signed [ais_pkg::SUM_W-1:0]    sum_c;
  logic signed [ais_pkg::PROD_W-1:0]   prod_c;
  logic                                sub_ok;
  logic [IW-1:0]                       sub_ix;
  logic [31:0]                         rd_val;
  logic                                rd_hit;
  logic                                wr_hit;
  logic                                load_go;
  logic                                store_go;

  ais_div_if #(.DW(ais_pkg::PROD_W), .VW(ais_pkg::COEF_W)) div_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] i);
    return (32'(i) + 1 >= NUM_INPUTS) ? '0 : IW'(32'(i) + 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // offset and multiply for the input in turn
  always_comb begin
    raw_sel = adc_raw_i[32'(idx_r)*ais_pkg::ADC_W +: ais_pkg::ADC_W];
    // full scale 1023 counts stands for 10 V or 20 mA; the
    // datapath keeps counts, units come from the coefficients
    if (raw_sel > ais_pkg::ADC_FULL_SCALE) begin
      raw_sel = ais_pkg::ADC_FULL_SCALE;
    end
    sum_c  = $signed({{(ais_pkg::SUM_W-ais_pkg::ADC_W){1'b0}}, raw_sel})
           + $signed({offset_r[idx_r][15], offset_r[idx_r]});
    // 17x16 bits product held at 33 bits, nothing dropped
    prod_c = $signed({{(ais_pkg::PROD_W-ais_pkg::SUM_W){sum_c[ais_pkg::SUM_W-1]}}, sum_c})
           * $signed({{(ais_pkg::PROD_W-ais_pkg::COEF_W){numer_r[idx_r][15]}}, numer_r[idx_r]});
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer decode, shared by the blocks below
  always_comb begin
    // a zero divisor never reaches the divider
    load_go  = (state_r == ais_pkg::AIS_ST_LOAD) && (denom_r[idx_r] != '0);
    store_go = (state_r == ais_pkg::AIS_ST_WAIT) && div_bus.done;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: load a division, wait for it, move to the next input
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_r <= ais_pkg::AIS_ST_LOAD;
      idx_r   <= '0;
    end else begin
      unique case (state_r)
        ais_pkg::AIS_ST_LOAD: begin
          if (load_go) begin
            state_r <= ais_pkg::AIS_ST_WAIT;
          end else begin
            // zero divisor: previous result kept, move on
            idx_r <= next_idx(idx_r);
          end
        end
        ais_pkg::AIS_ST_WAIT: begin
          if (store_go) begin
            idx_r   <= next_idx(idx_r);
            state_r <= ais_pkg::AIS_ST_LOAD;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // division request: operands captured on the load cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_bus.start    <= 1'b0;
      div_bus.dividend <= '0;
      div_bus.divisor  <= '0;
    end else begin
      div_bus.start <= load_go;
      if (load_go) begin
        div_bus.dividend <= prod_c;
        div_bus.divisor  <= denom_r[idx_r];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result store and refresh pulse
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      refresh_o <= 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        scaled_r[i] <= ais_pkg::SCALED_RST;
      end
    end else begin
      refresh_o <= store_go;
      if (store_go) begin
        scaled_r[idx_r] <= div_bus.quotient[ais_pkg::RESULT_W-1:0];
      end
    end
  end

  ais_divider #(
    .DW (ais_pkg::PROD_W),
    .VW (ais_pkg::COEF_W)
  ) u_div (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .div       (div_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // object dictionary decode
  always_comb begin
    sub_ok = (od_subidx_i >= ais_pkg::SUB_FIRST)
          && (32'(od_subidx_i) <= NUM_INPUTS);
    sub_ix = IW'(od_subidx_i - ais_pkg::SUB_FIRST);
    rd_hit = 1'b1;
    rd_val = '0;
    if (od_subidx_i == ais_pkg::SUB_COUNT) begin
      rd_hit = (od_index_i >= ais_pkg::IDX_SCALED) && (od_index_i <= ais_pkg::IDX_DENOMIN);
      rd_val = 32'(NUM_INPUTS);
    end else if (!sub_ok) begin
      rd_hit = 1'b0;
    end else begin
      unique case (od_index_i)
        ais_pkg::IDX_SCALED:    rd_val = scaled_r[sub_ix];
        ais_pkg::IDX_OFFSET:    rd_val = sext16(offset_r[sub_ix]);
        ais_pkg::IDX_NUMERATOR: rd_val = sext16(numer_r[sub_ix]);
        ais_pkg::IDX_DENOMIN:   rd_val = sext16(denom_r[sub_ix]);
        default:                rd_hit = 1'b0;
      endcase
    end
    // scaled entry and counts are read-only, writes there are refused
    wr_hit = sub_ok && (od_index_i >= ais_pkg::IDX_OFFSET)
          && (od_index_i <= ais_pkg::IDX_DENOMIN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // coefficient registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        offset_r[i] <= ais_pkg::OFFSET_RST;
        numer_r[i]  <= ais_pkg::NUMERATOR_RST;
        denom_r[i]  <= ais_pkg::DENOMIN_RST;
      end
    end else if (od_wr_i && wr_hit) begin
      unique case (od_index_i)
        ais_pkg::IDX_OFFSET:    offset_r[sub_ix] <= od_wdata_i[15:0];
        ais_pkg::IDX_NUMERATOR: numer_r[sub_ix]  <= od_wdata_i[15:0];
        default:                denom_r[sub_ix]  <= od_wdata_i[15:0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access answer, one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      od_rdata_o <= '0;
      od_ack_o   <= 1'b0;
      od_abort_o <= 1'b0;
    end else begin
      od_ack_o   <= 1'b0;
      od_abort_o <= 1'b0;
      if (od_wr_i) begin
        od_ack_o   <= wr_hit;
        od_abort_o <= !wr_hit;
      end else if (od_rd_i) begin
        od_ack_o   <= rd_hit;
        od_abort_o <= !rd_hit;
        od_rdata_o <= rd_hit ? rd_val : '0;
      end
    end
  end

endmodule // ais_scaler

// ===== test/ais_scaler_asserts.sv
// Purpose : port-level checks of the analog input scaling block
// Assumes : one clock, synchronous active-high reset
// Notes   : bound into every scaler instance
module ais_scaler_asserts #(
  parameter int NUM_INPUTS = 1
) (
  input wire logic                                 clk_sys_i,
  input wire logic                                 srst_i,
  input wire logic [NUM_INPUTS*ais_pkg::ADC_W-1:0] adc_raw_i,
  input wire logic                                 od_rd_i,
  input wire logic                                 od_wr_i,
  input wire logic [15:0]                          od_index_i,
  input wire logic [7:0]                           od_subidx_i,
  input wire logic [31:0]                          od_wdata_i,
  input wire logic [31:0]                          od_rdata_o,
  input wire logic                                 od_ack_o,
  input wire logic                                 od_abort_o,
  input wire logic                                 refresh_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_req; od_rd_i || od_wr_i; endsequence
  sequence s_read; od_rd_i && !od_wr_i; endsequence
  // indices 3320..3323 share the upper 14 bits
  sequence s_cnt_rd; s_read ##0 (od_subidx_i == ais_pkg::SUB_COUNT && od_index_i[15:2] == 14'h0CC8); endsequence
  sequence s_off_rd; s_read ##0 (od_index_i == ais_pkg::IDX_OFFSET && od_subidx_i == ais_pkg::SUB_FIRST); endsequence
  property p_answer; s_req |=> od_ack_o != od_abort_o; endproperty
  property p_quiet; !(od_rd_i || od_wr_i) |=> !od_ack_o && !od_abort_o; endproperty
  property p_scaled_ro; od_wr_i && od_index_i == ais_pkg::IDX_SCALED |=> od_abort_o; endproperty
  property p_cnt_ro; od_wr_i && od_subidx_i == ais_pkg::SUB_COUNT |=> od_abort_o; endproperty
  property p_cnt_rd; s_cnt_rd |=> od_ack_o && od_rdata_o == 32'(NUM_INPUTS); endproperty
  property p_rd_hold; !od_rd_i |=> $stable(od_rdata_o); endproperty
  property p_rf_gap; refresh_o |=> !refresh_o [*8]; endproperty
  property p_sign; s_off_rd |=> od_ack_o && od_rdata_o[31:16] == {16{od_rdata_o[15]}}; endproperty
  a_answer: assert property (p_answer) else $error("access not answered once");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_scaled_ro: assert property (p_scaled_ro) else $error("scaled value written");
  a_cnt_ro: assert property (p_cnt_ro) else $error("input count written");
  a_cnt_rd: assert property (p_cnt_rd) else $error("bad input count");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  a_rf_gap: assert property (p_rf_gap) else $error("refresh too close");
  a_sign: assert property (p_sign) else $error("offset not sign extended");
endmodule // ais_scaler_asserts

bind ais_scaler ais_scaler_asserts #(.NUM_INPUTS(NUM_INPUTS)) u_chk (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
  .adc_raw_i(adc_raw_i), .od_rd_i(od_rd_i), .od_wr_i(od_wr_i), .od_index_i(od_index_i),
  .od_subidx_i(od_subidx_i), .od_wdata_i(od_wdata_i), .od_rdata_o(od_rdata_o), .od_ack_o(od_ack_o),
  .od_abort_o(od_abort_o), .refresh_o(refresh_o));

// ===== test/ais_od_master.sv
// Purpose : fieldbus master model for object dictionary accesses
// Assumes : one access at a time, strobe lasts one clock
// Notes   : released index, subindex and data lines carry the inverse of their last value, strobes go low
module ais_od_master (
  input  wire logic        clk_sys_i,
  output logic             od_rd_o,
  output logic             od_wr_o,
  output logic [15:0]      od_index_o,
  output logic [7:0]       od_subidx_o,
  output logic [31:0]      od_wdata_o,
  input  wire logic [31:0] od_rdata_i,
  input  wire logic        od_ack_i,
  input  wire logic        od_abort_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    od_rd_o = 1'b0;
    od_wr_o = 1'b0;
    od_index_o = '0;
    od_subidx_o = '0;
    od_wdata_o = '0;
  end
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                        output logic ok, output logic ab, output logic [31:0] q);
    int c;
    @(posedge clk_sys_i);
    #1;
    od_wr_o = w;
    od_rd_o = !w;
    od_index_o = i;
    od_subidx_o = s;
    od_wdata_o = d;
    @(posedge clk_sys_i);
    #1;
    od_wr_o = 1'b0;
    od_rd_o = 1'b0;
    od_index_o = ~i;
    od_subidx_o = ~s;
    od_wdata_o = ~d;
    c = 0;
    while (!(od_ack_i || od_abort_i) && c < 4) begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end
    ok = od_ack_i || od_abort_i;
    ab = od_abort_i;
    q = od_rdata_i;
  endtask
endmodule // ais_od_master

// ===== test/ais_scaler_tb.sv
// Purpose : self-checking bench of the analog input scaling block
// Assumes : two inputs fitted
// Notes   : expected results computed with signed integer arithmetic
module ais_scaler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NI = 2;
  logic                    clk_sys_i;
  logic                    srst_i;
  logic [NI*ais_pkg::ADC_W-1:0] adc_raw;
  logic                    rd, wr, ack, abrt, rfs;
  logic [15:0]             idx;
  logic [7:0]              sub;
  logic [31:0]             wd, rdat;
  int                      err_total = 0;
  int                      n_tests = 0;
  ais_scaler #(.NUM_INPUTS(NI)) dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .adc_raw_i(adc_raw), .od_rd_i(rd),
    .od_wr_i(wr), .od_index_i(idx), .od_subidx_i(sub), .od_wdata_i(wd), .od_rdata_o(rdat), .od_ack_o(ack),
    .od_abort_o(abrt), .refresh_o(rfs));
  ais_od_master mst (.clk_sys_i(clk_sys_i), .od_rd_o(rd), .od_wr_o(wr), .od_index_o(idx), .od_subidx_o(sub),
    .od_wdata_o(wd), .od_rdata_i(rdat), .od_ack_i(ack), .od_abort_i(abrt));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                     input logic eab, input logic [31:0] eq);
    logic ok, ab;
    logic [31:0] q;
    mst.access(w, i, s, d, ok, ab, q);
    if (ok !== 1'b1) begin
      err_total++;
      end_sim();
    end
    chk({31'h0, ab}, {31'h0, eab});
    if (!w) chk(q, eq);
  endtask
  task automatic wait_rf(input int n);
    int c;
    repeat (n) begin
      c = 0;
      do begin
        @(posedge clk_sys_i);
        #1;
        c++;
      end while (rfs !== 1'b1 && c < 100);
      if (rfs !== 1'b1) begin
        err_total++;
        end_sim();
      end
    end
  endtask
  function automatic logic [31:0] ev(int raw, int off, int num, int den);
    return 32'((raw + off) * num / den);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1;
    adc_raw = '0;
    repeat (5) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ais_pkg::IDX_SCALED + 16'(i), ais_pkg::SUB_COUNT, 32'h0, 1'b0, 32'(NI));
      acc(1'b1, ais_pkg::IDX_SCALED + 16'(i), ais_pkg::SUB_COUNT, 32'h5, 1'b1, 32'h0);
      for (int s = 1; s <= NI; s++)
        if (i > 0) acc(1'b0, ais_pkg::IDX_SCALED + 16'(i), 8'(s), 32'h0, 1'b0, (i == 1) ? 32'h0 : 32'h1);
    end
    acc(1'b1, ais_pkg::IDX_SCALED, ais_pkg::SUB_FIRST, 32'h7, 1'b1, 32'h0);
    acc(1'b0, ais_pkg::IDX_OFFSET, 8'(NI + 1), 32'h0, 1'b1, 32'h0);
    acc(1'b0, 16'h3324, ais_pkg::SUB_FIRST, 32'h0, 1'b1, 32'h0);
    adc_raw = {10'd512, ais_pkg::ADC_FULL_SCALE};
    wait_rf(3);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h01, 32'h0, 1'b0, 32'd1023);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h02, 32'h0, 1'b0, 32'd512);
    acc(1'b1, ais_pkg::IDX_NUMERATOR, 8'h01, 32'(ais_pkg::VOLT_FS_MV), 1'b0, 32'h0);
    acc(1'b1, ais_pkg::IDX_NUMERATOR, 8'h02, 32'(ais_pkg::CURR_FS_UA), 1'b0, 32'h0);
    acc(1'b1, ais_pkg::IDX_DENOMIN, 8'h01, 32'd1023, 1'b0, 32'h0);
    acc(1'b1, ais_pkg::IDX_DENOMIN, 8'h02, 32'd1023, 1'b0, 32'h0);
    wait_rf(3);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h01, 32'h0, 1'b0, ev(1023, 0, ais_pkg::VOLT_FS_MV, 1023));
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h02, 32'h0, 1'b0, ev(512, 0, ais_pkg::CURR_FS_UA, 1023));
    // input 2 is frozen before its raw reading moves, so its held value stays known
    acc(1'b1, ais_pkg::IDX_DENOMIN, 8'h02, 32'h0, 1'b0, 32'h0);
    adc_raw = {10'd100, 10'd5};
    acc(1'b1, ais_pkg::IDX_OFFSET, 8'h01, 32'h1234_FFF6, 1'b0, 32'h0);
    acc(1'b1, ais_pkg::IDX_NUMERATOR, 8'h01, 32'h0000_FFF9, 1'b0, 32'h0);
    acc(1'b1, ais_pkg::IDX_DENOMIN, 8'h01, 32'h0000_FFFC, 1'b0, 32'h0);
    wait_rf(3);
    acc(1'b0, ais_pkg::IDX_OFFSET, 8'h01, 32'h0, 1'b0, 32'hFFFF_FFF6);
    acc(1'b0, ais_pkg::IDX_DENOMIN, 8'h02, 32'h0, 1'b0, 32'h0);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h01, 32'h0, 1'b0, ev(5, -10, -7, -4));
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h02, 32'h0, 1'b0, ev(512, 0, ais_pkg::CURR_FS_UA, 1023));
    // mid-run reset brings every coefficient and result back to its preset
    @(posedge clk_sys_i);
    #1;
    srst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h02, 32'h0, 1'b0, ais_pkg::SCALED_RST);
    acc(1'b0, ais_pkg::IDX_OFFSET, 8'h01, 32'h0, 1'b0, 32'h0);
    acc(1'b0, ais_pkg::IDX_NUMERATOR, 8'h01, 32'h0, 1'b0, 32'h1);
    acc(1'b0, ais_pkg::IDX_DENOMIN, 8'h02, 32'h0, 1'b0, 32'h1);
    wait_rf(2);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h01, 32'h0, 1'b0, 32'd5);
    acc(1'b0, ais_pkg::IDX_SCALED, 8'h02, 32'h0, 1'b0, 32'd100);
    end_sim();
  end
endmodule // ais_scaler_tb
